// ==== rtl/status_service_request_logic.sv ====
`timescale 1ns/1ps
`include "srq_cfg.svh"

module status_service_request_logic #(
    parameter int OPER_W = 16,
    parameter int CP_W = 6
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Register port
    input wire srq_pkg::bus_req_t bus,
    output logic [15:0] rdata,
    // Error events from command parser, one-cycle pulses
    input wire srq_pkg::err_evt_t err,
    // Raw condition inputs from outside the clock domain
    input wire logic [OPER_W-1:0] oper_cond_in,
    input wire logic [CP_W-1:0] cp_cond_in,
    // Service request and interrupt
    output logic srq,
    output logic irq
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] trans(input logic [15:0] now, input logic [15:0] old,
                                          input logic [15:0] ptr, input logic [15:0] ntr);
        trans = (now & ~old & ptr) | (~now & old & ntr);
    endfunction

    function automatic logic wr_at(input srq_pkg::bus_req_t b, input logic [3:0] a);
        wr_at = b.wr && (b.addr == a);
    endfunction

    function automatic logic rd_at(input srq_pkg::bus_req_t b, input logic [3:0] a);
        rd_at = b.rd && (b.addr == a);
    endfunction

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [OPER_W-1:0] oper_s1_r, oper_s2_r, oper_old_r;
    logic [CP_W-1:0] cp_s1_r, cp_s2_r, cp_old_r;
    logic [OPER_W-1:0] oper_cond_full;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            oper_s1_r <= '0;
            oper_s2_r <= '0;
            oper_old_r <= '0;
            cp_s1_r <= '0;
            cp_s2_r <= '0;
            cp_old_r <= '0;
        end else begin
            oper_s1_r <= oper_cond_in;
            oper_s2_r <= oper_s1_r;
            oper_old_r <= oper_cond_full;
            cp_s1_r <= cp_cond_in;
            cp_s2_r <= cp_s1_r;
            cp_old_r <= cp_s2_r;
        end
    end

    // ------------------------------------------------------------
    // Commands
    // ------------------------------------------------------------
    logic cmd_rst, cmd_cls, cmd_opc;
    always_comb begin
        cmd_rst = wr_at(bus, `ADDR_CMD) && bus.wdata[`CMD_RST_BIT];
        cmd_cls = wr_at(bus, `ADDR_CMD) && bus.wdata[`CMD_CLS_BIT] && !cmd_rst;
        cmd_opc = wr_at(bus, `ADDR_CMD) && bus.wdata[`CMD_OPC_BIT];
    end

    // ------------------------------------------------------------
    // Enable masks and transition filters
    // ------------------------------------------------------------
    logic [7:0] evt_en_r, sre_r;
    logic [15:0] oper_en_r, oper_ptr_r, oper_ntr_r, cp_en_r, cp_ptr_r, cp_ntr_r;
    logic [2:0] irq_mask_r;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            evt_en_r <= `RST_BYTE;
            sre_r <= `RST_BYTE;
            oper_en_r <= `RST_WORD;
            oper_ptr_r <= `RST_PTR;
            oper_ntr_r <= `RST_PTR;
            cp_en_r <= `RST_WORD;
            cp_ptr_r <= `RST_PTR;
            cp_ntr_r <= `RST_PTR;
            irq_mask_r <= 3'h0;
        end else if (cmd_rst) begin
            evt_en_r <= `RST_BYTE;
            sre_r <= `RST_BYTE;
            oper_en_r <= `RST_WORD;
            oper_ptr_r <= `RST_PTR;
            oper_ntr_r <= `RST_PTR;
            cp_en_r <= `RST_WORD;
            cp_ptr_r <= `RST_PTR;
            cp_ntr_r <= `RST_PTR;
            irq_mask_r <= 3'h0;
        end else begin
            if (wr_at(bus, `ADDR_EVT_EN)) evt_en_r <= bus.wdata[7:0];
            if (wr_at(bus, `ADDR_SRE)) sre_r <= bus.wdata[7:0] & 8'hA0;
            if (wr_at(bus, `ADDR_OPER_EN)) oper_en_r <= bus.wdata;
            if (wr_at(bus, `ADDR_OPER_PTR)) oper_ptr_r <= bus.wdata;
            if (wr_at(bus, `ADDR_OPER_NTR)) oper_ntr_r <= bus.wdata;
            if (wr_at(bus, `ADDR_CP_EN)) cp_en_r <= bus.wdata;
            if (wr_at(bus, `ADDR_CP_PTR)) cp_ptr_r <= bus.wdata;
            if (wr_at(bus, `ADDR_CP_NTR)) cp_ntr_r <= bus.wdata;
            if (wr_at(bus, `ADDR_IRQ_MASK)) irq_mask_r <= bus.wdata[2:0];
        end
    end

    // ------------------------------------------------------------
    // Call-processing group
    // ------------------------------------------------------------
    logic [15:0] cp_evt_r, cp_set;
    logic cp_sum;
    always_comb begin
        cp_set = trans(16'(cp_s2_r), 16'(cp_old_r), cp_ptr_r, cp_ntr_r);
        cp_sum = |(cp_evt_r & cp_en_r);
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cp_evt_r <= `RST_WORD;
        end else if (cmd_rst) begin
            cp_evt_r <= `RST_WORD;
        end else if (cmd_cls) begin
            cp_evt_r <= cp_set;
        end else if (rd_at(bus, `ADDR_CP_EVT)) begin
            cp_evt_r <= cp_set;
        end else begin
            cp_evt_r <= cp_evt_r | cp_set;
        end
    end

    // ------------------------------------------------------------
    // Operation group
    // ------------------------------------------------------------
    logic [15:0] oper_evt_r, oper_set;
    logic oper_sum;
    always_comb begin
        oper_cond_full = oper_s2_r;
        oper_cond_full[`OPER_CP_BIT] = cp_sum;
        oper_set = trans(16'(oper_cond_full), 16'(oper_old_r), oper_ptr_r, oper_ntr_r);
        oper_sum = |(oper_evt_r & oper_en_r);
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            oper_evt_r <= `RST_WORD;
        end else if (cmd_rst) begin
            oper_evt_r <= `RST_WORD;
        end else if (cmd_cls) begin
            oper_evt_r <= oper_set;
        end else if (rd_at(bus, `ADDR_OPER_EVT)) begin
            oper_evt_r <= oper_set;
        end else begin
            oper_evt_r <= oper_evt_r | oper_set;
        end
    end

    // ------------------------------------------------------------
    // Standard event group
    // ------------------------------------------------------------
    logic [7:0] evt_r, evt_set;
    logic esb_sum;
    always_comb begin
        evt_set = 8'h00;
        evt_set[`EVT_CME_BIT] = err.cmd_err;
        evt_set[`EVT_EXE_BIT] = err.exe_err;
        evt_set[`EVT_DDE_BIT] = err.dev_err;
        evt_set[`EVT_QRY_BIT] = err.qry_err;
        evt_set[`EVT_OPC_BIT] = cmd_opc;
        esb_sum = |(evt_r & evt_en_r);
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            evt_r <= `RST_BYTE;
        end else if (cmd_rst) begin
            evt_r <= `RST_BYTE;
        end else if (cmd_cls) begin
            // Clear and read keep events that arrive in the same cycle
            evt_r <= evt_set;
        end else if (rd_at(bus, `ADDR_EVT)) begin
            evt_r <= evt_set;
        end else begin
            evt_r <= evt_r | evt_set;
        end
    end

    // ------------------------------------------------------------
    // Status byte and service request
    // ------------------------------------------------------------
    logic [7:0] stb;
    logic srq_nxt;
    always_comb begin
        stb = 8'h00;
        stb[`STB_OSB_BIT] = oper_sum;
        stb[`STB_ESB_BIT] = esb_sum;
        srq_nxt = |(stb & sre_r);
        stb[`STB_RQS_BIT] = srq_nxt;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            srq <= 1'b0;
        end else begin
            srq <= srq_nxt;
        end
    end

    // ------------------------------------------------------------
    // Interrupt status
    // ------------------------------------------------------------
    logic [2:0] irq_st_r, irq_ev;
    logic srq_d_r, esb_d_r, osb_d_r;
    always_comb begin
        irq_ev = 3'h0;
        irq_ev[`IRQ_SRQ_BIT] = srq_nxt & ~srq_d_r;
        irq_ev[`IRQ_ESB_BIT] = esb_sum & ~esb_d_r;
        irq_ev[`IRQ_OSB_BIT] = oper_sum & ~osb_d_r;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            srq_d_r <= 1'b0;
            esb_d_r <= 1'b0;
            osb_d_r <= 1'b0;
        end else begin
            srq_d_r <= srq_nxt;
            esb_d_r <= esb_sum;
            osb_d_r <= oper_sum;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_st_r <= 3'h0;
        end else if (cmd_rst) begin
            irq_st_r <= 3'h0;
        end else if (cmd_cls) begin
            irq_st_r <= irq_ev;
        end else if (wr_at(bus, `ADDR_IRQ_ST)) begin
            // Write-one-to-clear; an edge in the same cycle still sets its bit
            irq_st_r <= (irq_st_r & ~bus.wdata[2:0]) | irq_ev;
        end else begin
            irq_st_r <= irq_st_r | irq_ev;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_st_r & irq_mask_r);
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata <= 16'h0000;
        end else if (bus.rd) begin
            unique case (bus.addr)
                `ADDR_EVT: rdata <= {8'h00, evt_r};
                `ADDR_EVT_EN: rdata <= {8'h00, evt_en_r};
                `ADDR_SRE: rdata <= {8'h00, sre_r};
                `ADDR_STB: rdata <= {8'h00, stb};
                `ADDR_OPER_EN: rdata <= oper_en_r;
                `ADDR_OPER_PTR: rdata <= oper_ptr_r;
                `ADDR_OPER_NTR: rdata <= oper_ntr_r;
                `ADDR_OPER_EVT: rdata <= oper_evt_r;
                `ADDR_CP_EN: rdata <= cp_en_r;
                `ADDR_CP_PTR: rdata <= cp_ptr_r;
                `ADDR_CP_NTR: rdata <= cp_ntr_r;
                `ADDR_CP_EVT: rdata <= cp_evt_r;
                `ADDR_IRQ_ST: rdata <= {13'h0000, irq_st_r};
                `ADDR_IRQ_MASK: rdata <= {13'h0000, irq_mask_r};
                default: rdata <= 16'h0000;
            endcase
        end else begin
            rdata <= 16'h0000;
        end
    end

endmodule

// ==== rtl/srq_cfg.svh ====
`ifndef SRQ_CFG_SVH
`define SRQ_CFG_SVH
// ------------------------------------------------------------
// Register offsets (word index on the plain port)
// ------------------------------------------------------------
`define ADDR_EVT      4'h0
`define ADDR_EVT_EN   4'h1
`define ADDR_SRE      4'h2
`define ADDR_STB      4'h3
`define ADDR_OPER_EN  4'h4
`define ADDR_OPER_PTR 4'h5
`define ADDR_OPER_NTR 4'h6
`define ADDR_OPER_EVT 4'h7
`define ADDR_CP_EN    4'h8
`define ADDR_CP_PTR   4'h9
`define ADDR_CP_NTR   4'hA
`define ADDR_CP_EVT   4'hB
`define ADDR_CMD      4'hC
`define ADDR_IRQ_ST   4'hD
`define ADDR_IRQ_MASK 4'hE
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define EVT_OPC_BIT   0
`define EVT_QRY_BIT   2
`define EVT_DDE_BIT   3
`define EVT_EXE_BIT   4
`define EVT_CME_BIT   5
`define STB_ESB_BIT   5
`define STB_RQS_BIT   6
`define STB_OSB_BIT   7
`define OPER_CP_BIT   9
`define CMD_RST_BIT   0
`define CMD_CLS_BIT   1
`define CMD_OPC_BIT   2
`define IRQ_SRQ_BIT   0
`define IRQ_ESB_BIT   1
`define IRQ_OSB_BIT   2
// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define RST_BYTE      8'h00
`define RST_WORD      16'h0000
`define RST_PTR       16'h0000
`endif

// ==== rtl/srq_pkg.sv ====
package srq_pkg;
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    typedef struct packed {
        logic cmd_err;
        logic exe_err;
        logic dev_err;
        logic qry_err;
    } err_evt_t;
endpackage

// ==== verif/srq_props.sv ====
`timescale 1ns/1ps
`include "srq_cfg.svh"
module srq_props #(
    parameter int OPER_W = 16,
    parameter int CP_W = 6
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Observed ports
    input wire srq_pkg::bus_req_t bus,
    input wire logic [15:0] rdata,
    input wire srq_pkg::err_evt_t err,
    input wire logic [OPER_W-1:0] oper_cond_in,
    input wire logic [CP_W-1:0] cp_cond_in,
    input wire logic srq,
    input wire logic irq
);
    // ----
    // Shadow of the masks
    // ----
    logic [7:0] ese_r;
    logic [7:0] sre_r;
    logic filt_r;
    logic wcmd;
    logic rd_evt;
    assign wcmd = bus.wr && bus.addr == `ADDR_CMD;
    assign rd_evt = bus.rd && bus.addr == `ADDR_EVT;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            {ese_r, sre_r, filt_r} <= 17'h00000;
        end else if (wcmd && bus.wdata[0]) begin
            {ese_r, sre_r, filt_r} <= 17'h00000;
        end else if (bus.wr) begin
            if (bus.addr == `ADDR_EVT_EN) ese_r <= bus.wdata[7:0];
            if (bus.addr == `ADDR_SRE) sre_r <= bus.wdata[7:0] & 8'hA0;
            if ((bus.addr == `ADDR_OPER_PTR || bus.addr == `ADDR_OPER_NTR) && |bus.wdata)
                filt_r <= 1'b1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_quiet_read;
        rd_evt && err == 4'h0;
    endsequence
    sequence s_cls_then_read;
        (wcmd && bus.wdata[1] && !bus.wdata[2] && err == 4'h0) ##1 rd_evt;
    endsequence
    property p_err_latch;
        (err != 4'h0 && !bus.wr) ##1 rd_evt |=> (rdata[5:2] & $past(err, 2)) == $past(err, 2);
    endproperty
    a_err_latch: assert property (p_err_latch) else $error("error not latched");
    property p_rd_clear;
        s_quiet_read ##1 s_quiet_read |=> rdata == 16'h0000;
    endproperty
    a_rd_clear: assert property (p_rd_clear) else $error("event read not cleared");
    property p_srq_err;
        (err.cmd_err && ese_r[5] && sre_r[5] && !bus.wr) ##1 !(bus.wr || rd_evt) |=> srq;
    endproperty
    a_srq_err: assert property (p_srq_err) else $error("service request missing");
    property p_srq_off;
        (sre_r == 8'h00)[*2] |-> !srq;
    endproperty
    a_srq_off: assert property (p_srq_off) else $error("request while masked");
    property p_sre_rd;
        bus.rd && bus.addr == `ADDR_SRE |=> rdata == {8'h00, $past(sre_r)};
    endproperty
    a_sre_rd: assert property (p_sre_rd) else $error("request mask readback wrong");
    property p_cls;
        s_cls_then_read |=> rdata == 16'h0000;
    endproperty
    a_cls: assert property (p_cls) else $error("clear status left events");
    property p_rst_cmd;
        wcmd && bus.wdata[0] |-> ##2 !srq;
    endproperty
    a_rst_cmd: assert property (p_rst_cmd) else $error("request after reset command");
    property p_filt;
        !filt_r && bus.rd && bus.addr == `ADDR_OPER_EVT |=> rdata == 16'h0000;
    endproperty
    a_filt: assert property (p_filt) else $error("closed filter passed a change");
endmodule
bind status_service_request_logic srq_props #(.OPER_W(OPER_W), .CP_W(CP_W)) i_props (
    .clk(clk), .reset(reset), .bus(bus), .rdata(rdata), .err(err),
    .oper_cond_in(oper_cond_in), .cp_cond_in(cp_cond_in), .srq(srq), .irq(irq));

// ==== verif/host_model.sv ====
`timescale 1ns/1ps
`include "srq_cfg.svh"
module host_model (
    // Clock
    input wire logic clk,
    // Register port
    output srq_pkg::bus_req_t bus,
    input wire logic [15:0] rdata
);
    initial bus = 22'h000000;
    // One bus cycle; q is the read data standing in that cycle
    task automatic op(input logic w, input logic r, input logic [3:0] a,
                      input logic [15:0] d, output logic [15:0] q);
        bus <= '{addr: a, wdata: d, wr: w, rd: r};
        @(posedge clk);
        q = rdata;
    endtask
    task automatic idle();
        logic [15:0] q;
        op(1'b0, 1'b0, 4'h0, 16'h0000, q);
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        logic [15:0] q;
        op(1'b1, 1'b0, a, d, q);
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] q);
        op(1'b0, 1'b1, a, 16'h0000, q);
        op(1'b0, 1'b0, 4'h0, 16'h0000, q);
    endtask
    // Reset command, then clear status, before any set-up
    task automatic start();
        wr(`ADDR_CMD, 16'h0001 << `CMD_RST_BIT);
        wr(`ADDR_CMD, 16'h0001 << `CMD_CLS_BIT);
    endtask
    // Commands run in order; wait for operation complete
    task automatic sync(output logic ok);
        logic [15:0] q;
        wr(`ADDR_CMD, 16'h0001 << `CMD_OPC_BIT);
        ok = 1'b0;
        for (int i = 0; i < 8 && !ok; i++) begin
            rd(`ADDR_EVT, q);
            ok = q[`EVT_OPC_BIT];
        end
    endtask
endmodule

// ==== verif/status_service_request_logic_tb.sv ====
`timescale 1ns/1ps
`include "srq_cfg.svh"
module status_service_request_logic_tb;
    logic clk = 1'b0;
    logic reset;
    srq_pkg::bus_req_t bus;
    logic [15:0] rdata;
    srq_pkg::err_evt_t err;
    logic [15:0] oper_cond_in;
    logic [5:0] cp_cond_in;
    logic srq;
    logic irq;
    logic [15:0] q;
    logic ok;
    int miscompares = 0;
    int comparisons = 0;
    always #5 clk = ~clk;
    status_service_request_logic #(.OPER_W(16), .CP_W(6)) i_dut (
        .clk(clk), .reset(reset), .bus(bus), .rdata(rdata), .err(err),
        .oper_cond_in(oper_cond_in), .cp_cond_in(cp_cond_in), .srq(srq), .irq(irq));
    host_model i_host (.clk(clk), .bus(bus), .rdata(rdata));
    // ----
    // Helpers
    // ----
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic pulse(input logic [3:0] e);
        err <= e;
        i_host.idle();
        err <= 4'h0;
    endtask
    task automatic wait_hi(input bit sel);
        int n;
        n = 0;
        while ((sel ? irq : srq) !== 1'b1 && n < 20) begin
            i_host.idle();
            n++;
        end
        if ((sel ? irq : srq) !== 1'b1) begin
            miscompares++;
            print_verdict();
        end
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_defaults();
        logic [3:0] a [6] = '{`ADDR_SRE, `ADDR_EVT_EN, `ADDR_OPER_PTR, `ADDR_CP_NTR, `ADDR_STB, 4'hF};
        foreach (a[i]) begin
            i_host.rd(a[i], q);
            check(q, 16'h0000);
        end
    endtask
    task automatic t_err_bits();
        for (int i = 0; i < 4; i++) begin
            pulse(4'h1 << i);
            i_host.rd(`ADDR_EVT, q);
            check(q, 16'h0004 << i);
        end
        pulse(4'h8);
        i_host.op(1'b0, 1'b1, `ADDR_EVT, 16'h0000, q);
        i_host.op(1'b0, 1'b1, `ADDR_EVT, 16'h0000, q);
        check(q, 16'h0020);
        i_host.op(1'b0, 1'b0, 4'h0, 16'h0000, q);
        check(q, 16'h0000);
    endtask
    task automatic t_srq();
        i_host.start();
        i_host.sync(ok);
        check({15'h0000, ok}, 16'h0001);
        i_host.wr(`ADDR_EVT_EN, 16'h003C);
        i_host.wr(`ADDR_IRQ_MASK, 16'h0007);
        i_host.wr(`ADDR_SRE, 16'h00FF);
        i_host.rd(`ADDR_SRE, q);
        check(q, 16'h00A0);
        pulse(4'h4);
        wait_hi(1'b0);
        i_host.rd(`ADDR_STB, q);
        check(q & 16'h00A0, 16'h0020);
        wait_hi(1'b1);
        i_host.rd(`ADDR_IRQ_ST, q);
        check(q, 16'h0003);
        i_host.wr(`ADDR_IRQ_ST, 16'h0007);
        i_host.wr(`ADDR_IRQ_MASK, 16'h0000);
        i_host.rd(`ADDR_IRQ_ST, q);
        check(q, 16'h0000);
        i_host.rd(`ADDR_EVT, q);
        check(q, 16'h0010);
        i_host.idle();
        check({15'h0000, srq}, 16'h0000);
        check({15'h0000, irq}, 16'h0000);
        i_host.wr(`ADDR_EVT_EN, 16'h0020);
        pulse(4'h2);
        repeat (4) i_host.idle();
        check({15'h0000, srq}, 16'h0000);
        i_host.rd(`ADDR_EVT, q);
        check(q, 16'h0008);
    endtask
    task automatic t_cls_rst();
        i_host.wr(`ADDR_EVT_EN, 16'h003C);
        pulse(4'h8);
        wait_hi(1'b0);
        i_host.wr(`ADDR_CMD, 16'h0002);
        i_host.rd(`ADDR_EVT, q);
        check(q, 16'h0000);
        i_host.idle();
        check({15'h0000, srq}, 16'h0000);
        pulse(4'h8);
        wait_hi(1'b0);
        i_host.wr(`ADDR_CMD, 16'h0001);
        i_host.rd(`ADDR_EVT, q);
        check(q, 16'h0000);
        i_host.rd(`ADDR_SRE, q);
        check(q, 16'h0000);
        i_host.rd(`ADDR_EVT_EN, q);
        check(q, 16'h0000);
        check({15'h0000, srq}, 16'h0000);
    endtask
    task automatic t_filt();
        oper_cond_in <= 16'hFFFF;
        cp_cond_in <= 6'h3F;
        repeat (6) i_host.idle();
        oper_cond_in <= 16'h0000;
        cp_cond_in <= 6'h00;
        repeat (6) i_host.idle();
        i_host.rd(`ADDR_OPER_EVT, q);
        check(q, 16'h0000);
        i_host.rd(`ADDR_CP_EVT, q);
        check(q, 16'h0000);
        i_host.wr(`ADDR_CP_EN, 16'h003F);
        i_host.wr(`ADDR_CP_PTR, 16'h003F);
        i_host.wr(`ADDR_OPER_PTR, 16'h0200);
        i_host.wr(`ADDR_OPER_EN, 16'h0200);
        i_host.wr(`ADDR_SRE, 16'h0080);
        i_host.idle();
        cp_cond_in <= 6'h02;
        wait_hi(1'b0);
        i_host.rd(`ADDR_STB, q);
        check(q & 16'h0080, 16'h0080);
    endtask
    initial begin
        reset = 1'b1;
        err = 4'h0;
        oper_cond_in = 16'h0000;
        cp_cond_in = 6'h00;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        t_defaults();
        t_err_bits();
        t_srq();
        t_cls_rst();
        t_filt();
        print_verdict();
    end
endmodule
